// ---- hw/rcad_cfg.svh ----
// Constants for the core execution datapath
`ifndef RCAD_CFG_SVH
`define RCAD_CFG_SVH
`define RCAD_DW 8
`define RCAD_IW 12
`define RCAD_AW 5
`define RCAD_PCW 10
// Nibble width for the digit carry
`define RCAD_NIB 4
// Instruction fields
`define RCAD_OP_HI 11
`define RCAD_OP_LO 8
`define RCAD_DEST_BIT 7
// Mapped special slots
`define RCAD_ADDR_IND 5'h00
`define RCAD_ADDR_PROG_LO 5'h02
`define RCAD_ADDR_STAT 5'h03
`define RCAD_ADDR_FSR 5'h04
// Status bit positions
`define RCAD_STAT_C 0
`define RCAD_STAT_DIGIT_CARRY 1
`define RCAD_STAT_Z 2
// Reset values and fixed steps
`define RCAD_NOP 12'h000
`define RCAD_PROG_RST 10'h000
`define RCAD_FETCH_STEP 10'h001
`define RCAD_STAT_RST 8'h18
`define RCAD_ACC_RST 8'h00
`define RCAD_FSR_RST 8'h00
`define RCAD_ZERO 8'h00
`define RCAD_SUM_ONE 9'h001
`define RCAD_NIB_ONE 5'h01
`endif

// ---- hw/rcad_pkg.sv ----
// Types for the core execution datapath
`default_nettype none
package rcad_pkg;
    typedef enum logic [3:0] {
        OP_NOP = 4'h0, OP_LOAD_FILE = 4'h1, OP_STORE_ACC = 4'h2, OP_ADD = 4'h3,
        OP_SUB = 4'h4, OP_AND = 4'h5, OP_OR = 4'h6, OP_XOR = 4'h7,
        OP_ROT_LEFT = 4'h8, OP_ROT_RIGHT = 4'h9, OP_COMPL = 4'ha, OP_CLR = 4'hb,
        OP_JUMP = 4'hc, OP_LOAD_LIT = 4'hd, OP_AND_LIT = 4'he, OP_OR_LIT = 4'hf
    } rcad_op_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
    } rcad_dbus_t;
endpackage
`default_nettype wire

// ---- hw/rcad_core.sv ----
// Execute datapath of a small 8-bit two-stage pipelined core
`timescale 1ns/1ps
`default_nettype none
`include "rcad_cfg.svh"
// Contract
// (RULE1) One cycle each, branches take two
// (RULE2) Thirty-three single-word instructions, one word each; the core decodes sixteen from a 4-bit op field
// (RULE3) Twelve-bit opcode fetched each cycle
// (RULE4) Fetch overlaps execute in two stages
// (RULE5) Separate program and 8-bit data buses
// (RULE6) Special registers incl. program counter data-mapped
// (RULE7) 8-bit add, subtract, shift, logic
// (RULE8) Arithmetic is two's complement
// (RULE9) Two operands: accumulator with file/literal
// (RULE10) Single operand: accumulator or file
// (RULE11) Accumulator 8-bit, not data-mapped
// (RULE12) ALU updates carry, digit carry, zero
// (RULE13) Subtract: carry and digit carry are not-borrow
// (RULE14) Zero set when result is zero
// (RULE15) Digit carry from low nibble
module rcad_core (
    input wire logic mclk, // Core clock
    input wire logic rst_n, // Synchronous reset, active low
    output logic [`RCAD_PCW-1:0] progAddr, // Program memory address
    input wire logic [`RCAD_IW-1:0] progData, // Instruction word, same domain
    output rcad_pkg::rcad_dbus_t dataBus, // Data bus request
    input wire logic [`RCAD_DW-1:0] dataRdata, // File read data, same domain
    output logic [`RCAD_DW-1:0] accum, // Working accumulator
    output logic [`RCAD_DW-1:0] status, // Status register
    output logic flush // Branch bubble in execute
);
    // Instruction format used here: [11:8] op, [7] dest to file, [4:0] file / [7:0] literal
    logic [`RCAD_PCW-1:0] programCounter; // Fetch address register
    logic [`RCAD_IW-1:0] instr; // Execute stage instruction
    logic [`RCAD_DW-1:0] fsr; // Indirect pointer
    logic [`RCAD_DW-1:0] stat; // Status flags
    logic [`RCAD_DW-1:0] wreg; // Accumulator, no address
    rcad_pkg::rcad_op_t op; // Decoded operation
    // Operand addressing: slot zero redirects through the pointer
    wire [`RCAD_AW-1:0] fAddr = instr[`RCAD_AW-1:0]; // Direct address
    wire isInd = (fAddr == `RCAD_ADDR_IND); // Indirect slot
    wire [`RCAD_AW-1:0] effAddr = isInd ? fsr[`RCAD_AW-1:0] : fAddr; // RULE6
    wire [`RCAD_DW-1:0] lit = instr[`RCAD_DW-1:0]; // Immediate
    wire toFile = instr[`RCAD_DEST_BIT]; // Destination select
    wire litOp = (op == rcad_pkg::OP_LOAD_LIT) || (op == rcad_pkg::OP_AND_LIT) ||
        (op == rcad_pkg::OP_OR_LIT); // Literal as second source
    // Mapped special register reads; every other slot comes from the file
    wire [`RCAD_DW-1:0] fileVal = (effAddr == `RCAD_ADDR_PROG_LO) ? programCounter[`RCAD_DW-1:0] :
        (effAddr == `RCAD_ADDR_STAT) ? stat : (effAddr == `RCAD_ADDR_FSR) ? fsr : dataRdata; // RULE6
    wire [`RCAD_DW-1:0] opB = litOp ? lit : fileVal; // RULE9 RULE10
    // Nine-bit sums keep the carry out of the top bit
    wire [`RCAD_DW:0] sumAdd = {1'b0, opB} + {1'b0, wreg}; // RULE7 RULE8
    // Subtract adds the inverted accumulator plus one, so carry high means no borrow
    wire [`RCAD_DW:0] sumSub = {1'b0, opB} + {1'b0, ~wreg} + `RCAD_SUM_ONE; // RULE8
    // Low nibble sums give the digit carry
    wire [`RCAD_NIB:0] nibAdd = {1'b0, opB[`RCAD_NIB-1:0]} + {1'b0, wreg[`RCAD_NIB-1:0]}; // RULE15
    wire [`RCAD_NIB:0] nibSub = {1'b0, opB[`RCAD_NIB-1:0]} + {1'b0, ~wreg[`RCAD_NIB-1:0]} +
        `RCAD_NIB_ONE; // RULE13 RULE15
    logic [`RCAD_DW-1:0] res; // ALU result
    logic newC; // Next carry
    logic newDigitCarry; // Next digit carry
    logic setsZ; // Op affects zero
    logic setsC; // Op affects carry
    logic setsDigitCarry; // Op affects digit carry
    wire branch = (op == rcad_pkg::OP_JUMP); // Two-cycle op
    assign op = rcad_pkg::rcad_op_t'(instr[`RCAD_OP_HI:`RCAD_OP_LO]); // RULE2 RULE3
    // ALU function select; flags default to their held values
    always_comb
    begin
        res = opB;
        newC = stat[`RCAD_STAT_C];
        newDigitCarry = stat[`RCAD_STAT_DIGIT_CARRY];
        setsZ = 1'b0;
        setsC = 1'b0;
        setsDigitCarry = 1'b0;
        case (op)
            rcad_pkg::OP_LOAD_FILE:
            begin
                setsZ = 1'b1; // Move only touches zero
            end
            rcad_pkg::OP_STORE_ACC:
            begin
                res = wreg; // Accumulator out to the file
            end
            rcad_pkg::OP_ADD:
            begin
                res = sumAdd[`RCAD_DW-1:0];
                newC = sumAdd[`RCAD_DW]; // RULE12
                newDigitCarry = nibAdd[`RCAD_NIB];
                setsZ = 1'b1;
                setsC = 1'b1;
                setsDigitCarry = 1'b1;
            end
            rcad_pkg::OP_SUB:
            begin
                res = sumSub[`RCAD_DW-1:0];
                newC = sumSub[`RCAD_DW]; // RULE13
                newDigitCarry = nibSub[`RCAD_NIB]; // RULE13
                setsZ = 1'b1;
                setsC = 1'b1;
                setsDigitCarry = 1'b1;
            end
            rcad_pkg::OP_AND, rcad_pkg::OP_AND_LIT:
            begin
                res = opB & wreg;
                setsZ = 1'b1;
            end
            rcad_pkg::OP_OR, rcad_pkg::OP_OR_LIT:
            begin
                res = opB | wreg;
                setsZ = 1'b1;
            end
            rcad_pkg::OP_XOR:
            begin
                res = opB ^ wreg;
                setsZ = 1'b1;
            end
            rcad_pkg::OP_ROT_LEFT:
            begin
                res = {opB[`RCAD_DW-2:0], stat[`RCAD_STAT_C]}; // RULE7
                newC = opB[`RCAD_DW-1];
                setsC = 1'b1;
            end
            rcad_pkg::OP_ROT_RIGHT:
            begin
                res = {stat[`RCAD_STAT_C], opB[`RCAD_DW-1:1]};
                newC = opB[0];
                setsC = 1'b1;
            end
            rcad_pkg::OP_COMPL:
            begin
                res = ~opB;
                setsZ = 1'b1;
            end
            rcad_pkg::OP_CLR:
            begin
                res = `RCAD_ZERO;
                setsZ = 1'b1;
            end
            default:
            begin
                res = opB; // No-op, jump and literal load pass the operand
            end
        endcase
    end
    // Destination decode: literal ops always land in the accumulator
    wire writesFile = toFile && !litOp && !branch && (op != rcad_pkg::OP_NOP);
    wire writesW = (!toFile && !branch && (op != rcad_pkg::OP_NOP)) || litOp; // RULE11
    wire newZ = (res == `RCAD_ZERO); // RULE14
    // Flags keep their value unless the op affects them
    wire [`RCAD_DW-1:0] next_stat = {stat[`RCAD_DW-1:`RCAD_STAT_Z+1], setsZ ? newZ : stat[`RCAD_STAT_Z],
        setsDigitCarry ? newDigitCarry : stat[`RCAD_STAT_DIGIT_CARRY],
        setsC ? newC : stat[`RCAD_STAT_C]}; // RULE12
    wire stWr = writesFile && (effAddr == `RCAD_ADDR_STAT); // Status written whole
    wire programCounterWr = writesFile && (effAddr == `RCAD_ADDR_PROG_LO); // Computed jump
    wire [`RCAD_PCW-1:0] branchTgt = {{(`RCAD_PCW-`RCAD_DW){1'b0}}, lit}; // Jump target
    // Next fetch address: jump, written low byte, or plain step
    wire [`RCAD_PCW-1:0] next_programCounter = branch ? branchTgt :
        programCounterWr ? {programCounter[`RCAD_PCW-1:`RCAD_DW], res} :
        programCounter + `RCAD_FETCH_STEP;
    // Pipeline: fetch while the previous word executes; a jump discards the fetched word
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            programCounter <= `RCAD_PROG_RST;
            instr <= `RCAD_NOP;
            flush <= 1'b0;
        end
        else
        begin
            programCounter <= next_programCounter; // RULE4
            instr <= (branch || programCounterWr) ? `RCAD_NOP : progData; // RULE1
            flush <= branch || programCounterWr;
        end
    end
    // Accumulator, status and pointer
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            wreg <= `RCAD_ACC_RST;
            stat <= `RCAD_STAT_RST;
            fsr <= `RCAD_FSR_RST;
        end
        else
        begin
            if (writesW)
                wreg <= res; // RULE11
            stat <= stWr ? res : next_stat; // RULE12
            if (writesFile && (effAddr == `RCAD_ADDR_FSR))
                fsr <= res; // RULE6
        end
    end
    // Outputs; mapped specials never reach the external file
    assign progAddr = programCounter; // RULE5
    assign accum = wreg;
    assign status = stat;
    assign dataBus.addr = {{(`RCAD_DW-`RCAD_AW){1'b0}}, effAddr}; // RULE5
    assign dataBus.wdata = res;
    assign dataBus.we = writesFile && !stWr && !programCounterWr && (effAddr != `RCAD_ADDR_FSR) && rst_n;
    // Checks
    // Jump in execute
    sequence s_jump;
        branch;
    endsequence
    // Bubble cycle: target loaded, fetched word discarded
    sequence s_bubble;
        flush && (instr == `RCAD_NOP) && (programCounter == $past(branchTgt));
    endsequence
    property p_sub_borrow;
        @(posedge mclk) disable iff (!rst_n)
        (op == rcad_pkg::OP_SUB && !stWr) |=> (stat[`RCAD_STAT_C] == $past(sumSub[`RCAD_DW]));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("carry not borrow"); // RULE13
    property p_zero;
        @(posedge mclk) disable iff (!rst_n)
        (setsZ && !stWr) |=> (stat[`RCAD_STAT_Z] == ($past(res) == `RCAD_ZERO));
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong"); // RULE14
    property p_branch;
        @(posedge mclk) disable iff (!rst_n)
        s_jump |=> s_bubble ##1 !flush;
    endproperty
    a_branch: assert property (p_branch) else $error("branch not two cycles"); // RULE1
    property p_seq;
        @(posedge mclk) disable iff (!rst_n)
        (!branch && !programCounterWr) |=> (programCounter == $past(programCounter) + `RCAD_FETCH_STEP) &&
            (instr == $past(progData));
    endproperty
    a_seq: assert property (p_seq) else $error("pipeline step wrong"); // RULE4
    property p_digit_carry;
        @(posedge mclk) disable iff (!rst_n)
        (op == rcad_pkg::OP_ADD && !stWr) |=> (stat[`RCAD_STAT_DIGIT_CARRY] == $past(nibAdd[`RCAD_NIB]));
    endproperty
    a_digit_carry: assert property (p_digit_carry) else $error("digit carry wrong"); // RULE15
    property p_sub_digit;
        @(posedge mclk) disable iff (!rst_n)
        (op == rcad_pkg::OP_SUB && !stWr) |=> (stat[`RCAD_STAT_DIGIT_CARRY] == $past(nibSub[`RCAD_NIB]));
    endproperty
    a_sub_digit: assert property (p_sub_digit) else $error("digit borrow wrong"); // RULE13
    property p_add;
        @(posedge mclk) disable iff (!rst_n)
        (op == rcad_pkg::OP_ADD && !toFile) |=> (wreg == $past(opB + wreg));
    endproperty
    a_add: assert property (p_add) else $error("add result wrong"); // RULE7
    property p_wkeep;
        @(posedge mclk) disable iff (!rst_n)
        (!writesW) |=> (wreg == $past(wreg));
    endproperty
    a_wkeep: assert property (p_wkeep) else $error("accumulator changed"); // RULE11
    property p_flags_keep;
        @(posedge mclk) disable iff (!rst_n)
        (!setsZ && !setsC && !setsDigitCarry && !stWr) |=> $stable(stat);
    endproperty
    a_flags_keep: assert property (p_flags_keep) else $error("status changed"); // RULE12
    property p_pointer_store;
        @(posedge mclk) disable iff (!rst_n)
        (writesFile && (effAddr == `RCAD_ADDR_FSR)) |=> (fsr == $past(res));
    endproperty
    a_pointer_store: assert property (p_pointer_store) else $error("pointer store lost"); // RULE6
    property p_lit;
        @(posedge mclk) disable iff (!rst_n)
        (op == rcad_pkg::OP_LOAD_LIT) |=> (wreg == $past(lit));
    endproperty
    a_lit: assert property (p_lit) else $error("literal load wrong"); // RULE9
endmodule // rcad_core
`default_nettype wire

// ---- tb/rcad_mem_model.sv ----
// Program memory and data file facing the core
`timescale 1ns/1ps
`default_nettype none
`include "rcad_cfg.svh"
module rcad_mem_model (
    input wire logic mclk, // Core clock
    input wire logic [`RCAD_PCW-1:0] progAddr, // Fetch address
    output logic [`RCAD_IW-1:0] progData, // Instruction word
    input wire rcad_pkg::rcad_dbus_t dataBus, // Data request
    output logic [`RCAD_DW-1:0] dataRdata // File read data
);
    logic [`RCAD_IW-1:0] prog [0:63]; // Program words, loaded by the bench
    logic [`RCAD_DW-1:0] file [0:31]; // General file registers
    // Whole word each cycle; the small store aliases higher addresses
    assign progData = prog[progAddr[5:0]];
    // Read answers in the same cycle as the address
    assign dataRdata = file[dataBus.addr[4:0]];
    // Write lands at the edge that ends the execute cycle
    always @(posedge mclk)
    begin
        if (dataBus.we)
        begin
            file[dataBus.addr[4:0]] <= dataBus.wdata;
        end
    end
endmodule // rcad_mem_model
`default_nettype wire

// ---- tb/risc_core_alu_datapath_test.sv ----
// Self-checking bench for the core execution datapath
`timescale 1ns/1ps
`default_nettype none
`include "rcad_cfg.svh"
`define CHK(what, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("MISMATCH %s expected %h seen %h", what, exp, got); \
        end \
    end
module risc_core_alu_datapath_test;
    logic mclk; // Core clock
    logic rst_n; // Reset, active low
    logic [`RCAD_PCW-1:0] progAddr; // Fetch address
    logic [`RCAD_IW-1:0] progData; // Instruction word
    rcad_pkg::rcad_dbus_t dataBus; // Data request
    logic [`RCAD_DW-1:0] dataRdata; // File read data
    logic [`RCAD_DW-1:0] accum; // Accumulator
    logic [`RCAD_DW-1:0] status; // Status register
    logic flush; // Branch bubble
    int error_cnt; // Mismatches
    int n_checks; // Comparisons
    rcad_core i_dut (.mclk(mclk), .rst_n(rst_n), .progAddr(progAddr), .progData(progData),
        .dataBus(dataBus), .dataRdata(dataRdata), .accum(accum), .status(status), .flush(flush));
    rcad_mem_model i_mem (.mclk(mclk), .progAddr(progAddr), .progData(progData),
        .dataBus(dataBus), .dataRdata(dataRdata));
    // Free-running clock
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Let n edges pass, then look once outputs settle
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Reset for ten cycles with the store filled with no-ops
    task automatic restart();
        @(posedge mclk);
        rst_n <= 1'b0;
        for (int i = 0; i < 64; i++) i_mem.prog[i] <= `RCAD_NOP;
        repeat (10) @(posedge mclk);
    endtask
    // Release reset at one edge, then n edges more
    task automatic go(input int n);
        rst_n <= 1'b1;
        step(n);
    endtask
    // Add and subtract with carry, digit carry and zero
    task automatic arith_flags();
        restart();
        i_mem.prog[0] <= 12'hd0f;
        i_mem.prog[1] <= 12'h290;
        i_mem.prog[2] <= 12'hd01;
        i_mem.prog[3] <= 12'h310;
        i_mem.prog[4] <= 12'h410;
        i_mem.prog[5] <= 12'hd0f;
        i_mem.prog[6] <= 12'h410;
        go(5);
        `CHK("file", 8'h0f, i_mem.file[16])
        `CHK("add", 8'h10, accum)
        `CHK("add flags", 8'h1a, status)
        step(1);
        `CHK("sub", 8'hff, accum)
        `CHK("sub flags", 8'h1a, status)
        step(2);
        `CHK("sub zero", 8'h00, accum)
        `CHK("zero flags", 8'h1f, status)
    endtask
    // Branch bubble, indirect read and shift
    task automatic branch_path();
        restart();
        i_mem.prog[0] <= 12'hd10;
        i_mem.prog[1] <= 12'h284;
        i_mem.prog[2] <= 12'hd5a;
        i_mem.prog[3] <= 12'h290;
        i_mem.prog[4] <= 12'hd00;
        i_mem.prog[5] <= 12'hc08;
        i_mem.prog[6] <= 12'hd77;
        i_mem.prog[7] <= 12'hd77;
        i_mem.prog[8] <= 12'h100;
        i_mem.prog[9] <= 12'h810;
        go(7);
        `CHK("bubble", 1'b1, flush)
        `CHK("target", 10'h008, progAddr)
        step(1);
        `CHK("skipped", 8'h00, accum)
        `CHK("bubble end", 1'b0, flush)
        `CHK("indirect addr", 8'h10, dataBus.addr)
        `CHK("indirect no store", 1'b0, dataBus.we)
        step(1);
        `CHK("indirect", 8'h5a, accum)
        step(1);
        `CHK("rotate", 8'hb4, accum)
        `CHK("rotate flags", 8'h18, status)
    endtask
    // Verdict and end of run
    task automatic wrap_up();
        if (error_cnt == 0 && n_checks > 0)
        begin
            $display("Testbench passed");
        end
        else
        begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Cut a hang short
    initial
    begin
        #20000;
        error_cnt++;
        wrap_up();
    end
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        error_cnt = 0;
        n_checks = 0;
        arith_flags();
        branch_path();
        wrap_up();
    end
endmodule // risc_core_alu_datapath_test
`default_nettype wire
